// ---- upbc_pkg.sv ----
// Shared constants and types for the ULPI transceiver bus control block
package upbc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // System clock and reset pin timing
  localparam int unsigned SYS_CLK_MHZ    = 125;
  localparam int unsigned RESET_MIN_NS   = 1000;
  localparam int unsigned RESET_MIN_CYC  = (RESET_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned LOW_CNT_W      = 8;
  localparam logic [LOW_CNT_W-1:0] RESET_LOW_LAST = LOW_CNT_W'(RESET_MIN_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Start-up timing
  localparam int unsigned CNT_W          = 20;
  typedef logic [CNT_W-1:0] upbc_count_t;
  // Input-clock mode preparation window and chosen point inside it
  localparam int unsigned PREP_MIN_US    = 400;
  localparam int unsigned PREP_MAX_US    = 500;
  localparam int unsigned PREP_US        = 450;
  localparam int unsigned PREP_CYC       = PREP_US * SYS_CLK_MHZ;
  // Recovery by select code: 26, 12, 52, 24, 19.2, 27, 38.4, 13 MHz
  localparam int unsigned RECOV_TYP_US [8] = '{1030, 2240, 520, 1120, 1400, 1000, 700, 2070};
  localparam int unsigned RECOV_MAX_US [8] = '{2280, 3490, 1770, 2370, 2650, 2250, 1950, 3320};
  localparam int unsigned RECOV_CYC [8] = '{
    RECOV_TYP_US[0] * SYS_CLK_MHZ, RECOV_TYP_US[1] * SYS_CLK_MHZ,
    RECOV_TYP_US[2] * SYS_CLK_MHZ, RECOV_TYP_US[3] * SYS_CLK_MHZ,
    RECOV_TYP_US[4] * SYS_CLK_MHZ, RECOV_TYP_US[5] * SYS_CLK_MHZ,
    RECOV_TYP_US[6] * SYS_CLK_MHZ, RECOV_TYP_US[7] * SYS_CLK_MHZ};

  ////////////////////////////////////////////////////////////////////////////////
  // Bus values and buffer shape
  localparam logic [7:0]  BUS_IDLE       = 8'h00;
  localparam int unsigned BUF_DEPTH      = 2;

  // One byte on the stream with its end marker
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } upbc_byte_s;

  // System side sequencing
  typedef enum {
    SS_OFF,
    SS_WAIT_REF,
    SS_START,
    SS_READY
  } upbc_sys_state_e;

  // Link side bus ownership
  typedef enum {
    LS_IDLE,
    LS_CMD,
    LS_TURN_UP,
    LS_SEND,
    LS_TURN_DOWN
  } upbc_link_state_e;

endpackage

// ---- upbc_pair_buffer.sv ----
// Small FIFO holding command bytes between the bus and the crossing
`timescale 1ns/100ps
`default_nettype none

module upbc_pair_buffer #(
  parameter int unsigned WIDTH = $bits(upbc_pkg::upbc_byte_s),
  parameter int unsigned DEPTH = upbc_pkg::BUF_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic                  next_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] slot [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic [AW:0]      next_fill;

  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign next_fill  = fill + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_ready   = fill != (AW+1)'(DEPTH);
  // Lookahead lets the producer promise room one cycle ahead
  assign next_ready = next_fill != (AW+1)'(DEPTH);
  assign out_valid  = fill != '0;
  assign out_data   = slot[rd_ptr];

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end
    else
    begin
      if (push) wr_ptr <= step(wr_ptr);
      if (pop) rd_ptr <= step(rd_ptr);
      fill <= next_fill;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push) slot[wr_ptr] <= in_data;
  end

endmodule

`default_nettype wire

// ---- upbc_ulpi_phy_bus_control.sv ----
// Transceiver side ULPI bus ownership, reset pin handling and start-up sequencing
// Summary of operation
// - With bytes for the link, raise direction and own the data bus.
// - With nothing to send, keep direction low and watch for link commands.
// - Stop means the byte in the previous cycle was the last one.
// - Reset pin low suspends the device, all ULPI outputs released.
// - Reset pin may change anytime; it is synchronised before use.
// - Pin low at least 1 us then high resets registers and state machines.
// - Bus power switch enable stays low after reset until turned on.
// - Reference pin carries selected frequency, or link's 60 MHz in input-clock mode.
// - Release direction within the recovery limit after reference clock starts.
// - Input-clock mode preparation time lies between 0.4 ms and 0.5 ms.
// - Reference clock needs no alignment to the ULPI signals.
// - Automatic resume lets a host finish start-up in under 1 ms.
// - Assert next to accept each link byte; link then presents the next.
// - In output-clock mode drive the 60 MHz interface clock out.
`timescale 1ns/100ps
`default_nettype none

module upbc_ulpi_phy_bus_control #(
  parameter int unsigned PREP_CYCLES        = upbc_pkg::PREP_CYC,
  parameter int unsigned RECOVERY_CYCLES [8] = upbc_pkg::RECOV_CYC
) (
  // System clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  // ULPI interface clock domain
  input  wire logic                 clk_link,
  // Device pins
  input  wire logic                 reset_in_n,
  input  wire logic                 reference_clock_in,
  input  wire logic [2:0]           reference_frequency_select,
  input  wire logic                 interface_clock_strap_in,
  output logic                      interface_clock_out,
  output logic                      interface_clock_oe,
  output logic                      bus_power_switch_en,
  // ULPI bus
  output logic                      dir,
  output logic                      nxt,
  output logic                      control_oe,
  input  wire logic                 stp,
  input  wire logic [7:0]           data_in,
  output logic [7:0]                data_out,
  output logic                      data_oe,
  // Bytes toward the link
  input  wire logic                 rx_valid,
  output logic                      rx_ready,
  input  wire upbc_pkg::upbc_byte_s rx_byte,
  // Commands from the link
  output logic                      cmd_valid,
  input  wire logic                 cmd_ready,
  output upbc_pkg::upbc_byte_s      cmd_byte,
  // Power and resume control
  input  wire logic                 bus_power_request,
  input  wire logic                 automatic_resume,
  input  wire logic                 resume_detect,
  output logic                      resume_drive,
  output logic                      phy_ready
);

  ////////////////////////////////////////////////////////////////////////////////
  // System domain: pin synchronisers
  logic [1:0]                      rstn_sync;
  logic [1:0]                      ref_sync;
  logic [1:0]                      strap_sync;
  logic [2:0]                      reference_frequency_select_s1;
  logic [2:0]                      reference_frequency_select_s2;
  logic                            ref_prev;

  // Pins cross on two flops; the reference needs no alignment to anything
  always_ff @(posedge clk_sys)
  begin
    rstn_sync  <= {rstn_sync[0], reset_in_n};
    ref_sync   <= {ref_sync[0], reference_clock_in};
    strap_sync <= {strap_sync[0], interface_clock_strap_in};
    reference_frequency_select_s1  <= reference_frequency_select;
    reference_frequency_select_s2  <= reference_frequency_select_s1;
    ref_prev   <= ref_sync[1];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // System domain: sequencing
  upbc_pkg::upbc_sys_state_e       state;
  upbc_pkg::upbc_sys_state_e       next_state;
  logic [upbc_pkg::LOW_CNT_W-1:0]  low_cnt;
  upbc_pkg::upbc_count_t           cnt;
  logic                            input_mode;
  logic [2:0]                      reference_frequency_select_cap;
  logic                            pins_oe;

  wire pin_high  = rstn_sync[1];
  wire ref_edge  = ref_sync[1] & ~ref_prev;
  wire long_low  = ~pin_high & (low_cnt == upbc_pkg::RESET_LOW_LAST);
  wire upbc_pkg::upbc_count_t start_limit = input_mode ?
    upbc_pkg::upbc_count_t'(PREP_CYCLES) :
    upbc_pkg::upbc_count_t'(RECOVERY_CYCLES[reference_frequency_select_cap]);
  wire start_done = cnt == start_limit - 1'b1;

  always_comb
  begin
    next_state = state;
    case (state)
      upbc_pkg::SS_OFF:      if (pin_high) next_state = upbc_pkg::SS_WAIT_REF;
      upbc_pkg::SS_WAIT_REF: if (ref_edge) next_state = upbc_pkg::SS_START;
      upbc_pkg::SS_START:    if (start_done) next_state = upbc_pkg::SS_READY;
      upbc_pkg::SS_READY:    next_state = upbc_pkg::SS_READY;
      default:               next_state = upbc_pkg::SS_OFF;
    endcase
    // A long low pulse forces the off state once it has lasted 1 us, before release
    if (long_low) next_state = upbc_pkg::SS_OFF;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state     <= upbc_pkg::SS_OFF;
      low_cnt   <= '0;
      cnt       <= '0;
      phy_ready <= 1'b0;
      pins_oe   <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      low_cnt   <= (pin_high | long_low) ? '0 : low_cnt + 1'b1;
      cnt       <= (state == upbc_pkg::SS_START) ? cnt + 1'b1 : '0;
      phy_ready <= next_state == upbc_pkg::SS_READY;
      pins_oe   <= pin_high;
    end
  end

  // Straps are caught after release while our clock driver is still off
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      input_mode <= 1'b0;
      reference_frequency_select_cap <= 3'h0;
    end
    else if (state == upbc_pkg::SS_OFF && pin_high)
    begin
      input_mode <= strap_sync[1];
      reference_frequency_select_cap <= reference_frequency_select_s2;
    end
  end

  // Power switch and resume follow the sequencer
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      bus_power_switch_en <= 1'b0;
      resume_drive        <= 1'b0;
      interface_clock_oe  <= 1'b0;
    end
    else
    begin
      bus_power_switch_en <= phy_ready & bus_power_request;
      resume_drive        <= phy_ready & automatic_resume & resume_detect;
      interface_clock_oe  <= pin_high & ~input_mode & (state != upbc_pkg::SS_OFF);
    end
  end

  // The interface clock itself is forwarded, not re-timed
  assign interface_clock_out = clk_link;
  assign control_oe          = pins_oe;

  ////////////////////////////////////////////////////////////////////////////////
  // System domain: word crossings
  upbc_pkg::upbc_byte_s            rx_word;
  logic                            rx_req;
  logic [1:0]                      rxa_sync;
  logic                            rx_ack;
  logic                            cmd_req;
  logic                            cmd_ack;
  logic [1:0]                      cmq_sync;
  upbc_pkg::upbc_byte_s            cx_word;

  // Word is held stable while a request is outstanding
  assign rx_ready  = phy_ready & (rx_req == rxa_sync[1]);
  assign cmd_valid = phy_ready & (cmq_sync[1] != cmd_ack);
  assign cmd_byte  = cx_word;

  always_ff @(posedge clk_sys)
  begin
    rxa_sync <= {rxa_sync[0], rx_ack};
    cmq_sync <= {cmq_sync[0], cmd_req};
    if (reset | ~phy_ready)
    begin
      rx_req  <= 1'b0;
      cmd_ack <= 1'b0;
    end
    else
    begin
      if (rx_valid & rx_ready) rx_req <= ~rx_req;
      if (cmd_valid & cmd_ready) cmd_ack <= ~cmd_ack;
    end
    if (rx_valid & rx_ready) rx_word <= rx_byte;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: ULPI bus
  logic [1:0]                      ready_sync;
  logic [1:0]                      rxr_sync;
  logic [1:0]                      cak_sync;
  upbc_pkg::upbc_link_state_e      lstate;
  logic                            dir_q;
  logic                            nxt_q;
  logic                            drive;
  logic                            sent_last;
  logic                            held_valid;
  upbc_pkg::upbc_byte_s            held;
  upbc_pkg::upbc_byte_s            buf_in;
  upbc_pkg::upbc_byte_s            buf_out;
  logic                            buf_in_ready;
  logic                            buf_next_ready;
  logic                            buf_out_valid;

  always_ff @(posedge clk_link)
  begin
    ready_sync <= {ready_sync[0], phy_ready};
    rxr_sync   <= {rxr_sync[0], rx_req};
    cak_sync   <= {cak_sync[0], cmd_ack};
  end

  wire link_rst  = ~ready_sync[1];
  wire pending   = rxr_sync[1] != rx_ack;
  wire cmd_free  = cmd_req == cak_sync[1];
  wire is_idle   = lstate == upbc_pkg::LS_IDLE;
  wire in_cmd    = lstate == upbc_pkg::LS_CMD;
  wire in_send   = lstate == upbc_pkg::LS_SEND;
  wire accept    = in_cmd & nxt_q & ~stp;
  wire stop_cmd  = in_cmd & stp;
  wire go_rx     = is_idle & pending & ~held_valid;
  wire start_cmd = is_idle & ~pending & ~held_valid & (data_in != upbc_pkg::BUS_IDLE);
  wire finish    = in_send & nxt_q & sent_last;
  wire load      = pending & ((lstate == upbc_pkg::LS_TURN_UP) | (in_send & ~finish));
  wire buf_push  = held_valid & buf_in_ready & (held.last | accept | stop_cmd);
  wire buf_pop   = buf_out_valid & cmd_free;
  wire next_nxt  = load | ((start_cmd | (in_cmd & ~stp)) & buf_next_ready);
  wire next_dir  = go_rx | (dir_q & ~finish & (lstate != upbc_pkg::LS_TURN_DOWN));

  assign buf_in   = '{data: held.data, last: held.last | stop_cmd};
  assign dir      = dir_q;
  assign nxt      = nxt_q;
  // Data pins stay released in both turnaround cycles
  assign data_oe  = pins_oe & drive;

  always_ff @(posedge clk_link)
  begin
    if (link_rst)
      lstate <= upbc_pkg::LS_TURN_DOWN;
    else
      case (lstate)
        upbc_pkg::LS_IDLE:      if (go_rx) lstate <= upbc_pkg::LS_TURN_UP;
                                else if (start_cmd) lstate <= upbc_pkg::LS_CMD;
        upbc_pkg::LS_CMD:       if (stp) lstate <= upbc_pkg::LS_IDLE;
        upbc_pkg::LS_TURN_UP:   lstate <= upbc_pkg::LS_SEND;
        upbc_pkg::LS_SEND:      if (finish) lstate <= upbc_pkg::LS_TURN_DOWN;
        upbc_pkg::LS_TURN_DOWN: if (!dir_q) lstate <= upbc_pkg::LS_IDLE;
        default:                lstate <= upbc_pkg::LS_IDLE;
      endcase
  end

  // Direction stays high until start-up ends, then falls once
  always_ff @(posedge clk_link)
  begin
    if (link_rst)
    begin
      dir_q  <= 1'b1;
      nxt_q  <= 1'b0;
      drive  <= 1'b0;
      rx_ack <= 1'b0;
    end
    else
    begin
      dir_q <= next_dir;
      nxt_q <= next_nxt;
      drive <= (lstate == upbc_pkg::LS_TURN_UP) | (in_send & ~finish);
      if (load) rx_ack <= ~rx_ack;
    end
    if (load)
    begin
      data_out  <= rx_word.data;
      sent_last <= rx_word.last;
    end
  end

  // Each accepted byte waits at least one cycle to learn whether stop follows
  always_ff @(posedge clk_link)
  begin
    if (link_rst)
      held_valid <= 1'b0;
    else if (accept)
      held_valid <= 1'b1;
    else if (buf_push)
      held_valid <= 1'b0;
    if (accept)
      held <= '{data: data_in, last: 1'b0};
    else if (stop_cmd)
      held.last <= 1'b1;
  end

  always_ff @(posedge clk_link)
  begin
    if (link_rst)
      cmd_req <= 1'b0;
    else if (buf_pop)
      cmd_req <= ~cmd_req;
    if (buf_pop) cx_word <= buf_out;
  end

  // A stalled receiver fills this and withholds next
  upbc_pair_buffer #(
    .WIDTH ($bits(upbc_pkg::upbc_byte_s)),
    .DEPTH (upbc_pkg::BUF_DEPTH)
  ) u_cmd_buffer (
    .clk        (clk_link),
    .reset      (link_rst),
    .in_valid   (buf_push),
    .in_ready   (buf_in_ready),
    .next_ready (buf_next_ready),
    .in_data    (buf_in),
    .out_valid  (buf_out_valid),
    .out_ready  (cmd_free),
    .out_data   (buf_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_data_needs_dir: assert property (
    @(posedge clk_link) disable iff (link_rst) drive |-> dir_q)
    else $error("data driven while direction low");

  a_idle_dir_low: assert property (
    @(posedge clk_link) disable iff (link_rst) is_idle |-> !dir_q && !drive)
    else $error("direction high in idle");

  a_stop_marks_last: assert property (
    @(posedge clk_link) disable iff (link_rst)
    (stop_cmd && held_valid) |-> (buf_push && buf_in.last) or ##1 (held_valid && held.last))
    else $error("byte before stop not marked last");

  a_suspend_release: assert property (
    @(posedge clk_sys) disable iff (reset)
    !rstn_sync[1] |=> !control_oe && !data_oe && !interface_clock_oe)
    else $error("outputs driven while suspended");

  a_long_low_reset: assert property (
    @(posedge clk_sys) disable iff (reset)
    (!pin_high && low_cnt == upbc_pkg::RESET_LOW_LAST) |=> state == upbc_pkg::SS_OFF ##1 !phy_ready)
    else $error("long reset pulse did not restart");

  a_power_off: assert property (
    @(posedge clk_sys) disable iff (reset) !phy_ready |=> !bus_power_switch_en)
    else $error("power switch enabled before ready");

  a_start_bound: assert property (
    @(posedge clk_sys) disable iff (reset)
    (state == upbc_pkg::SS_START && !input_mode)
      |-> cnt < upbc_pkg::RECOV_MAX_US[reference_frequency_select_cap] * upbc_pkg::SYS_CLK_MHZ)
    else $error("recovery limit exceeded");

  a_prep_exact: assert property (
    @(posedge clk_sys) disable iff (reset)
    ($rose(phy_ready) && input_mode) |-> $past(cnt) == PREP_CYCLES - 1)
    else $error("preparation time off");

  a_nxt_has_room: assert property (
    @(posedge clk_link) disable iff (link_rst) (in_cmd && nxt_q) |-> buf_in_ready)
    else $error("next given without buffer room");

  a_turn_quiet: assert property (
    @(posedge clk_link) disable iff (link_rst) (dir_q != $past(dir_q)) |-> !drive)
    else $error("data driven in turnaround");

endmodule

`default_nettype wire

// ---- upbc_link_model.sv ----
// Behavioural model of the link controller facing the ULPI bus
`timescale 1ns/100ps
`default_nettype none

module upbc_link_model (
  // Link clock
  input  wire logic       clk_link,
  // ULPI bus as the link sees it
  input  wire logic       dir,
  input  wire logic       nxt,
  input  wire logic [7:0] bus,
  output logic            stp,
  output logic [7:0]      link_data,
  output logic            link_oe
);
  ////////////////////////////////////////////////////////////////////////////////
  // Byte queues filled and read by the bench
  logic [7:0] tx_q [$];
  logic [7:0] rx_q [$];
  logic       dir_q = 1'b0;

  initial
  begin
    stp       = 1'b0;
    link_data = 8'h00;
    link_oe   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Stream handling
  always @(posedge clk_link)
  begin
    dir_q <= dir;
    stp   <= 1'b0;
    // Bytes from the transceiver count only when next is high
    if (dir && dir_q && nxt)
      rx_q.push_back(bus);
    if (link_oe && nxt)
    begin
      void'(tx_q.pop_front());
      if (tx_q.size() > 0)
        link_data <= tx_q[0];
      else
      begin
        // Bus let go in the stop cycle, so only the pull-down shows
        link_oe <= 1'b0;
        stp     <= 1'b1;
      end
    end
    else if (!link_oe && !dir && !dir_q && !stp && tx_q.size() > 0)
    begin
      // Never start inside a turnaround cycle
      link_oe   <= 1'b1;
      link_data <= tx_q[0];
    end
  end
endmodule

`default_nettype wire

// ---- upbc_ulpi_phy_bus_control_tb.sv ----
// Self-checking bench for the ULPI transceiver bus control block
`timescale 1ns/100ps
`default_nettype none

module upbc_ulpi_phy_bus_control_tb;
  ////////////////////////////////////////////////////////////////////////////////
  // Short start-up counts keep the run brief
  localparam int PREP    = 260;
  localparam int REC [8] = '{100, 120, 140, 160, 180, 200, 220, 240};

  typedef struct packed {
    logic [2:0]  sel;
    logic        strap;
    logic [31:0] limit;
  } upbc_row_s;

  logic                 clk_sys = 1'b0;
  logic                 clk_link = 1'b0;
  logic                 reset = 1'b1;
  logic                 reset_in_n = 1'b0;
  logic                 reference_clock_in = 1'b0;
  logic [2:0]           sel = 3'h0;
  logic                 strap_pin = 1'b0;
  logic                 bus_power_request = 1'b0;
  logic                 automatic_resume = 1'b0;
  logic                 resume_detect = 1'b0;
  logic                 rx_valid = 1'b0;
  upbc_pkg::upbc_byte_s rx_byte = '0;
  logic                 cmd_ready = 1'b1;
  logic                 ck_out, ck_oe, bus_power_switch_en, dir, nxt, control_oe;
  logic                 data_oe, rx_ready, cmd_valid, resume_drive, phy_ready;
  logic                 stp, link_oe;
  logic [7:0]           data_out, link_data;
  upbc_pkg::upbc_byte_s cmd_byte;
  upbc_pkg::upbc_byte_s cmd_q [$];
  int                   err_count = 0;
  int                   comparisons = 0;
  // Wire levels: data bus has a pull-down, clock pin reads back its strap when released
  wire logic [7:0]      bus = data_oe ? data_out : (link_oe ? link_data : 8'h00);
  wire logic            strap_in = ck_oe ? ck_out : strap_pin;

  upbc_ulpi_phy_bus_control #(
    .PREP_CYCLES     (PREP),
    .RECOVERY_CYCLES (REC)
  ) i_upbc_ulpi_phy_bus_control (
    .clk_sys (clk_sys), .reset (reset), .clk_link (clk_link),
    .reset_in_n (reset_in_n), .reference_clock_in (reference_clock_in),
    .reference_frequency_select (sel), .interface_clock_strap_in (strap_in),
    .interface_clock_out (ck_out), .interface_clock_oe (ck_oe),
    .bus_power_switch_en (bus_power_switch_en), .dir (dir), .nxt (nxt),
    .control_oe (control_oe), .stp (stp), .data_in (bus), .data_out (data_out),
    .data_oe (data_oe), .rx_valid (rx_valid), .rx_ready (rx_ready), .rx_byte (rx_byte),
    .cmd_valid (cmd_valid), .cmd_ready (cmd_ready), .cmd_byte (cmd_byte),
    .bus_power_request (bus_power_request), .automatic_resume (automatic_resume),
    .resume_detect (resume_detect), .resume_drive (resume_drive), .phy_ready (phy_ready)
  );

  upbc_link_model i_upbc_link_model (
    .clk_link (clk_link), .dir (dir), .nxt (nxt), .bus (bus),
    .stp (stp), .link_data (link_data), .link_oe (link_oe)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clocks, command capture and helpers
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end

  // Odd offset keeps link edges away from system edges
  initial
  begin
    #37;
    forever #80 clk_link = ~clk_link;
  end

  always @(posedge clk_sys)
  begin
    if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
      cmd_q.push_back(cmd_byte);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_sys(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic send_rx(input logic [7:0] d, input logic l);
    int n;
    n = 0;
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_byte  <= {d, l};
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (rx_ready !== 1'b1 && n < 2000);
    rx_valid <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #400000;
    err_count++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    upbc_row_s  rows [9];
    logic [7:0] exp_rx [3];
    int         cnt;
    for (int i = 0; i < 9; i++)
      rows[i] = '{sel: 3'(i), strap: 1'(i == 8), limit: (i == 8) ? PREP : REC[i]};
    exp_rx = '{8'hA1, 8'hB2, 8'hC3};
    wait_sys(10);
    reset <= 1'b0;
    wait_sys(3);
    check({phy_ready, bus_power_switch_en, control_oe}, 3'h0);
    // Each row restarts the device with a long pin pulse
    foreach (rows[i])
    begin
      sel                <= rows[i].sel;
      strap_pin          <= rows[i].strap;
      reset_in_n         <= 1'b0;
      reference_clock_in <= 1'b0;
      wait_sys(130);
      check(phy_ready, 1'b0);
      reset_in_n <= 1'b1;
      wait_sys(10);
      reference_clock_in <= 1'b1;
      cnt = 0;
      while (phy_ready !== 1'b1 && cnt < 1000)
      begin
        @(posedge clk_sys);
        cnt++;
      end
      check(cnt >= rows[i].limit && cnt <= rows[i].limit + 8, 1'b1);
      check({ck_oe, bus_power_switch_en}, {!rows[i].strap, 1'b0});
      wait_sys(120);
      check(dir, 1'b0);
    end
    bus_power_request <= 1'b1;
    wait_sys(3);
    check(bus_power_switch_en, 1'b1);
    // Three bytes toward the link, last one closes ownership
    foreach (exp_rx[i])
      send_rx(exp_rx[i], 1'(i == 2));
    cnt = 0;
    while (i_upbc_link_model.rx_q.size() < 3 && cnt < 2000)
    begin
      @(posedge clk_sys);
      cnt++;
    end
    foreach (exp_rx[i])
      check(i_upbc_link_model.rx_q[i], exp_rx[i]);
    wait_sys(100);
    check({dir, data_oe}, 2'h0);
    // Command of eight bytes while the receiver stalls; the buffer must refuse
    cmd_ready <= 1'b0;
    for (int i = 0; i < 8; i++)
      i_upbc_link_model.tx_q.push_back(8'h41 + 8'(i));
    wait_sys(800);
    check({nxt, i_upbc_link_model.tx_q.size() != 0}, 2'h1);
    cmd_ready <= 1'b1;
    wait_sys(3000);
    check(cmd_q.size(), 8);
    for (int i = 0; i < 8; i++)
      check(cmd_q[i], {8'h41 + 8'(i), 1'(i == 7)});
    automatic_resume <= 1'b1;
    resume_detect    <= 1'b1;
    wait_sys(3);
    check(resume_drive, 1'b1);
    automatic_resume <= 1'b0;
    wait_sys(3);
    check(resume_drive, 1'b0);
    // Short pin pulse only releases the outputs, no restart
    reset_in_n <= 1'b0;
    wait_sys(6);
    check({control_oe, data_oe, ck_oe}, 3'h0);
    wait_sys(14);
    reset_in_n <= 1'b1;
    wait_sys(10);
    check({phy_ready, control_oe}, 2'h3);
    report_and_stop();
  end
endmodule

`default_nettype wire
